// *** sim/pps_equip_model.sv ***
// Purpose: External equipment: volume feedback and event trigger line.
// Assumes: Pulses are two or more cycles wide for the synchroniser.
// Notes:   Event line stretches a one-cycle request to four cycles.
`timescale 1ns/10ps
module pps_equip_model (
  input  wire logic clk_i,
  input  wire logic motor_on_i,
  input  wire logic fire_i,
  output logic      step_o,
  output logic      event_o
);
  logic [1:0] ph = 2'h0;
  logic [2:0] ev = 3'h0;
  // One feedback edge every four cycles while the motor turns.
  always_ff @(posedge clk_i) begin
    ph <= motor_on_i ? ph + 2'h1 : 2'h0;
    ev <= fire_i ? 3'h4 : (ev != 3'h0 ? ev - 3'h1 : 3'h0);
  end
  assign step_o  = ph[1];
  assign event_o = ev != 3'h0;
endmodule

// *** sim/pps_seq_sva.sv ***
// Purpose: Port-level checks of the program sequencer.
// Assumes: One clock, synchronous active-high reset.
// Notes:   Bound into every sequencer instance.
`timescale 1ns/10ps
module pps_seq_sva (
  input wire logic                   clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_ack_o,
  input wire logic                   prog_out_o, motor_on_o, running_o,
  input wire logic [31:0]            wb_dat_o,
  input wire pps_pkg::pps_phase_type phase_o
);
  // All checks share the one clock and are silent while reset holds.
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  property p_ack_one; wb_ack_o |=> !wb_ack_o; endproperty
  a_ack_one: assert property (p_ack_one) else $error("ack held too long");
  property p_ack_due; wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o; endproperty
  a_ack_due: assert property (p_ack_due) else $error("ack missing");
  property p_ack_why; wb_ack_o |-> $past(wb_cyc_i && wb_stb_i); endproperty
  a_ack_why: assert property (p_ack_why) else $error("ack without request");
  property p_range; phase_o inside {[6'h01:6'h29]}; endproperty
  a_range: assert property (p_range) else $error("phase out of range");
  property p_rst; $past(rst_i) |-> phase_o == 6'h01 && !prog_out_o && !motor_on_o; endproperty
  a_rst: assert property (p_rst) else $error("bad reset state");
  property p_idle; !running_o && !$past(running_o) |-> !motor_on_o; endproperty
  a_idle: assert property (p_idle) else $error("motor on while idle");
  property p_line; $changed(prog_out_o) |-> $past(running_o); endproperty
  a_line: assert property (p_line) else $error("line moved while idle");
  property p_dat; $changed(wb_dat_o) |-> wb_ack_o; endproperty
  a_dat: assert property (p_dat) else $error("read data moved without ack");
endmodule
bind pps_sequencer pps_seq_sva u_sva (
  .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o),
  .prog_out_o(prog_out_o), .motor_on_o(motor_on_o), .running_o(running_o),
  .wb_dat_o(wb_dat_o), .phase_o(phase_o));

// *** sim/testbench.sv ***
// Purpose: Self-checking bench for the program sequencer.
// Assumes: Tick shortened to 20 cycles per second.
// Notes:   Each program ends with a stop phase since the table is not reset.
`timescale 1ns/10ps
module testbench;
  import pps_pkg::*;
  logic clk_i = 0, rst_i = 1, cyc = 0, we = 0, fire = 0, ack, step, ev, pout, mon, run;
  logic [11:0] adr = 12'h000;
  logic [31:0] dat = 32'h0, q, d, dat_o;
  pps_phase_type ph;
  logic trig = 0, start = 0, pin = 1, wdr;
  logic [10:0] rate;
  int err_count = 0, n_compared = 0, hold_cyc = 0;
  always #20 clk_i = ~clk_i;
  pps_sequencer #(.TICK_CYCLES(20)) DUT (
    .clk_i, .rst_i, .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we), .wb_adr_i(adr),
    .wb_sel_i(4'hf), .wb_dat_i(dat), .wb_dat_o(dat_o), .wb_ack_o(ack), .trig_i(trig),
    .event_i(ev), .start_i(start), .step_i(step), .prog_in_i(pin), .prog_out_o(pout),
    .motor_on_o(mon), .motor_withdraw_o(wdr), .motor_rate_o(rate), .running_o(run),
    .phase_o(ph));
  pps_equip_model u_eq (.clk_i, .motor_on_i(mon), .fire_i(fire), .step_o(step), .event_o(ev));
  // Counts cycles spent in phase three, where the timed hold sits.
  always @(posedge clk_i) if (run === 1'b1 && ph === 6'h03) hold_cyc++;
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      err_count++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic wb(input logic w, input logic [11:0] a, input logic [31:0] v);
    @(posedge clk_i);
    cyc <= 1;
    we <= w;
    adr <= a;
    dat <= v;
    do @(posedge clk_i); while (ack !== 1'b1);
    q = dat_o;
    cyc <= 0;
  endtask
  function automatic logic [31:0] op(pps_op_type o, int v);
    return {o, 12'h005, v[15:0]};
  endfunction
  task automatic run_prog(input logic [31:0] w[$], input int lim);
    foreach (w[i]) wb(1, ADR_TABLE + 12'(4 * i), w[i]);
    wb(0, ADR_DISPENSED, 0);
    d = q;
    wb(1, ADR_CTRL, 32'h1);
    repeat (lim) begin
      @(posedge clk_i);
      if (run !== 1'b1) break;
    end
  endtask
  task automatic t_flow;
    hold_cyc = 0;
    run_prog('{op(OP_LINE_HIGH, 0), op(OP_FLOW, 3), op(OP_TIMED_HOLD, 2), op(OP_STOP, 0)}, 300);
    chk(pout, 1);
    chk(hold_cyc inside {[40:44]}, 1);
    wb(0, ADR_DISPENSED, 0);
    chk(q - d, 3);
    $display("flow and hold test done");
  endtask
  task automatic t_loop;
    run_prog('{op(OP_LOOP_BEGIN, 0), op(OP_FLOW, 1), op(OP_LOOP_TALLY, 3), op(OP_GOTO, 6),
               op(OP_FLOW, 4), op(OP_STOP, 0)}, 400);
    chk(ph, 6);
    wb(0, ADR_DISPENSED, 0);
    chk(q - d, 3);
    wb(0, 12'h010, 0);
    chk(q, 0);
    $display("loop test done");
  endtask
  task automatic t_trap;
    run_prog('{op(OP_HOOK_ON, 4), op(OP_CLEAR_HOOKS, 0), op(OP_FLOW, 0), op(OP_STOP, 0)}, 60);
    fire <= 1;
    @(posedge clk_i) fire <= 0;
    repeat (20) @(posedge clk_i);
    chk(run, 1);
    wb(1, ADR_CTRL, 32'h2);
    run_prog('{op(OP_HOOK_ON, 4), op(OP_FLOW, 0), op(OP_STOP, 0), op(OP_LINE_LOW, 0),
               op(OP_STOP, 0)}, 60);
    fire <= 1;
    @(posedge clk_i) fire <= 0;
    repeat (20) @(posedge clk_i);
    chk({run, pout, ph}, {2'b00, 6'h05});
    $display("trap test done");
  endtask
  // Branch on a low input, operator choice, pedal release as a redirected trap
  // cutting a hold short, then a reload of all that was dispensed.
  task automatic t_ext;
    pin <= 0;
    wb(1, ADR_CHOICE, 2);
    run_prog('{op(OP_BRANCH_LOW, 3), op(OP_STOP, 0), op(OP_CHOICE_HOLD, 0),
               op(OP_CHOICE_LABEL, 1), op(OP_STOP, 0), op(OP_CHOICE_LABEL, 2),
               op(OP_HOOK_REDIR, 0), op(OP_HOOK_ON, 10), op(OP_TIMED_HOLD, 5),
               op(OP_RELOAD, 0), op(OP_STOP, 0)}, 20);
    chk({run, ph}, {1'b1, 6'h03});
    wb(1, ADR_CTRL, 32'h4);
    // Pedal mode is set first, so pressing the pedal is not an event.
    trig <= 1;
    start <= 1;
    repeat (20) @(posedge clk_i);
    chk({run, ph}, {1'b1, 6'h09});
    trig <= 0;
    start <= 0;
    repeat (8) @(posedge clk_i);
    chk({ph, mon, wdr, rate}, {6'h0a, 2'b11, 11'h005});
    repeat (400) begin
      @(posedge clk_i);
      if (run !== 1'b1) break;
    end
    chk({run, ph}, {1'b0, 6'h0b});
    wb(0, ADR_DISPENSED, 0);
    chk(q, 0);
    $display("choice and reload test done");
  endtask
  task automatic tally_and_finish;
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  // The tests need under two thousand cycles; the limit leaves ample margin.
  initial begin
    #400000;
    err_count++;
    tally_and_finish;
  end
  initial begin
    repeat (6) @(posedge clk_i);
    rst_i <= 0;
    t_flow;
    t_loop;
    t_trap;
    t_ext;
    tally_and_finish;
  end
endmodule

// *** src/pps_phase_table.sv ***
// Purpose: Stored phase table, one 32-bit word per phase.
// Assumes: Written only by the register bus; the core only reads it.
// Notes:   Two combinational read ports, one for the core and one for the bus.

`timescale 1ns/10ps

module pps_phase_table (
  // Clock.
  input  wire logic                  clk_i,
  // Bus side.
  input  wire logic                  wr_en_i,
  input  wire logic [5:0]            wr_idx_i,
  input  wire logic [31:0]           wr_data_i,
  input  wire logic [5:0]            rd_idx_i,
  output logic      [31:0]           rd_data_o,
  // Core side.
  pps_tbl_if.mem                     tbl
);
  import pps_pkg::*;

  logic [31:0] mem [PPS_PHASES];

  // Table contents are not reset; software loads a program before start.
  always_ff @(posedge clk_i) begin
    if (wr_en_i) begin
      mem[wr_idx_i] <= wr_data_i;
    end
  end

  // Out of range indices read as a stop phase.
  assign rd_data_o = (32'(rd_idx_i) < PPS_PHASES) ? mem[rd_idx_i] : 32'h0;
  assign tbl.word  = (32'(tbl.idx) < PPS_PHASES) ? mem[tbl.idx] : 32'h0;

endmodule

// *** src/pps_pkg.sv ***
// Purpose: Shared constants and types of the pumping program sequencer.
// Assumes: Phase words are 32 bits; phases are numbered from one.
// Notes:   Every field position, offset and reset value used by the logic lives here.

package pps_pkg;

  // ----------------------------------------------------------------------
  // Phase table geometry
  // ----------------------------------------------------------------------
  localparam int                PPS_PHASES    = 41;
  localparam int                PPS_PH_W      = 6;
  typedef logic [PPS_PH_W-1:0]  pps_phase_type;
  localparam pps_phase_type     PPS_FIRST     = 6'h01;
  localparam pps_phase_type     PPS_LAST      = 6'h29;
  localparam pps_phase_type     PPS_PH_ONE    = 6'h01;

  // ----------------------------------------------------------------------
  // Phase word layout
  // ----------------------------------------------------------------------
  localparam int                PPS_OP_HI     = 31;
  localparam int                PPS_OP_LO     = 28;
  localparam int                PPS_DIR_BIT   = 27;
  localparam int                PPS_RATE_HI   = 26;
  localparam int                PPS_RATE_LO   = 16;
  localparam int                PPS_VOL_HI    = 15;
  localparam int                PPS_VOL_LO    = 0;
  localparam int                PPS_CNT_HI    = 6;

  typedef enum logic [3:0] {
    OP_STOP         = 4'h0,
    OP_FLOW         = 4'h1,
    OP_LOOP_BEGIN   = 4'h2,
    OP_LOOP_TALLY   = 4'h3,
    OP_GOTO         = 4'h4,
    OP_CHOICE_HOLD  = 4'h5,
    OP_CHOICE_LABEL = 4'h6,
    OP_CLEAR_HOOKS  = 4'h7,
    OP_HOOK_ON      = 4'h8,
    OP_LINE_HIGH    = 4'h9,
    OP_LINE_LOW     = 4'ha,
    OP_TIMED_HOLD   = 4'hb,
    OP_BRANCH_LOW   = 4'hc,
    OP_HOOK_REDIR   = 4'hd,
    OP_RELOAD       = 4'he
  } pps_op_type;

  // ----------------------------------------------------------------------
  // Sequencer states, one-hot
  // ----------------------------------------------------------------------
  typedef enum logic [5:0] {
    ST_IDLE   = 6'h01,
    ST_FETCH  = 6'h02,
    ST_FLOW   = 6'h04,
    ST_HOLD   = 6'h08,
    ST_CHOICE = 6'h10,
    ST_SEARCH = 6'h20
  } pps_state_type;

  // ----------------------------------------------------------------------
  // Register map (byte addresses) and fields
  // ----------------------------------------------------------------------
  localparam int                PPS_ADR_W     = 12;
  localparam logic [11:0]       ADR_CTRL      = 12'h000;
  localparam logic [11:0]       ADR_STATUS    = 12'h004;
  localparam logic [11:0]       ADR_CHOICE    = 12'h008;
  localparam logic [11:0]       ADR_DISPENSED = 12'h00c;
  localparam logic [11:0]       ADR_TABLE     = 12'h100;
  localparam logic [11:0]       ADR_TABLE_END = 12'h1a4;
  localparam int                CTRL_START    = 0;
  localparam int                CTRL_STOP     = 1;
  localparam int                CTRL_PEDAL    = 2;
  localparam int                STAT_RUN      = 8;
  localparam int                STAT_LINE     = 9;
  localparam int                STAT_ARMED    = 10;
  localparam int                STAT_ERROR    = 11;
  localparam int                STAT_REDIR    = 12;
  localparam int                STAT_ST_LO    = 16;

  // ----------------------------------------------------------------------
  // Synchroniser bit positions and timing
  // ----------------------------------------------------------------------
  localparam int                SYN_TRIG      = 0;
  localparam int                SYN_EVENT     = 1;
  localparam int                SYN_START     = 2;
  localparam int                SYN_STEP      = 3;
  localparam int                PPS_CLK_HZ    = 25_000_000;
  localparam int                PPS_TICK_S    = 1;

endpackage

// *** src/pps_sec_tick.sv ***
// Purpose: One-second tick for timed holds.
// Assumes: restart_i is a one-cycle pulse on entry to a hold.
// Notes:   The count restarts so a hold never ends early on a stale tick.

`timescale 1ns/10ps

module pps_sec_tick #(
  parameter int TICK_CYCLES = 25_000_000
) (
  // Clock and reset.
  input  wire logic clk_i,
  input  wire logic rst_i,
  // Control.
  input  wire logic restart_i,
  output logic      tick_o
);

  logic [31:0] cnt;

  // Free-running divider, restarted at the start of each hold.
  always_ff @(posedge clk_i) begin
    if (rst_i || restart_i) begin
      cnt <= 32'h0;
    end else if (cnt == 32'(TICK_CYCLES - 1)) begin
      cnt <= 32'h0;
    end else begin
      cnt <= cnt + 32'h1;
    end
  end

  assign tick_o = !restart_i && (cnt == 32'(TICK_CYCLES - 1));

endmodule

// *** src/pps_sequencer.sv ***
// Purpose: Runs a stored pumping program phase by phase.
// Assumes: Classic Wishbone register bus; step_i pulses once per volume unit.
// Notes:   Pins are synchronised by two flip-flops before use.
//
// The register offsets and the Wishbone interface to the registers were chosen for this implementation.

`timescale 1ns/10ps

module pps_sequencer #(
  parameter int TICK_CYCLES = pps_pkg::PPS_CLK_HZ * pps_pkg::PPS_TICK_S
) (
  // Clock and reset.
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // Wishbone slave.
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [11:0] wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  // Equipment and operator pins.
  input  wire logic        trig_i,
  input  wire logic        event_i,
  input  wire logic        start_i,
  input  wire logic        step_i,
  input  wire logic        prog_in_i,
  output logic             prog_out_o,
  // Motor drive.
  output logic             motor_on_o,
  output logic             motor_withdraw_o,
  output logic      [10:0] motor_rate_o,
  // Status.
  output logic             running_o,
  output pps_pkg::pps_phase_type phase_o
);
  import pps_pkg::*;

  // ----------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------
  typedef struct packed {
    pps_state_type state;
    pps_phase_type phase;
    pps_phase_type loop_start;
    pps_phase_type hook_target;
    pps_phase_type choice;
    pps_phase_type search;
    logic [6:0]    loop_cnt;
    logic [15:0]   hold_left;
    logic [15:0]   delivered;
    logic [15:0]   target;
    logic [15:0]   dispensed;
    logic [10:0]   rate;
    logic          motor_on;
    logic          withdraw;
    logic          is_reload;
    logic          hook_armed;
    logic          redirect;
    logic          out_line;
    logic          pedal;
    logic          error;
    logic          ack;
    logic [31:0]   rdata;
    logic [3:0]    s1;
    logic [3:0]    s2;
    logic [3:0]    q;
    logic          in_s1;
    logic          in_s2;
  } pps_core_type;

  pps_core_type s;
  pps_core_type next_s;

  pps_tbl_if     tbl ();
  logic          tick;
  logic          tick_restart;
  logic [31:0]   bus_word;
  logic [31:0]   lane_mask;
  logic          take;
  logic          tbl_hit;
  logic [5:0]    bus_idx;
  logic          tbl_wr;
  pps_op_type    op;
  pps_phase_type operand;
  logic          trig_ev;
  logic          trap_ev;
  logic          toggle_ev;
  logic          start_ev;
  logic          step_ev;
  logic          sw_start;
  logic          sw_stop;

  // ----------------------------------------------------------------------
  // Submodules
  // ----------------------------------------------------------------------
  pps_phase_table u_table (
    .clk_i     (clk_i),
    .wr_en_i   (tbl_wr),
    .wr_idx_i  (bus_idx),
    .wr_data_i ((bus_word & ~lane_mask) | (wb_dat_i & lane_mask)),
    .rd_idx_i  (bus_idx),
    .rd_data_o (bus_word),
    .tbl       (tbl.mem)
  );

  pps_sec_tick #(
    .TICK_CYCLES (TICK_CYCLES)
  ) u_tick (
    .clk_i     (clk_i),
    .rst_i     (rst_i),
    .restart_i (tick_restart),
    .tick_o    (tick)
  );

  // ----------------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------------
  // Byte enables widen to a bit mask so table words merge lane by lane.
  for (genvar lane = 0; lane < 4; lane++) begin : g_lane
    assign lane_mask[8*lane +: 8] = {8{wb_sel_i[lane]}};
  end

  assign take     = wb_cyc_i && wb_stb_i && !s.ack;
  assign tbl_hit  = (wb_adr_i >= ADR_TABLE) && (wb_adr_i < ADR_TABLE_END);
  assign bus_idx  = 6'((wb_adr_i - ADR_TABLE) >> 2);
  assign tbl_wr   = take && wb_we_i && tbl_hit;
  assign sw_start = take && wb_we_i && (wb_adr_i == ADR_CTRL) && wb_sel_i[0] &&
                    wb_dat_i[CTRL_START];
  assign sw_stop  = take && wb_we_i && (wb_adr_i == ADR_CTRL) && wb_sel_i[0] &&
                    wb_dat_i[CTRL_STOP];

  // ----------------------------------------------------------------------
  // Pin events, read from the second synchroniser stage only
  // ----------------------------------------------------------------------
  assign trig_ev   = s.pedal ? (!s.s2[SYN_TRIG] && s.q[SYN_TRIG])
                             : (s.s2[SYN_TRIG] && !s.q[SYN_TRIG]);
  assign trap_ev   = (s.s2[SYN_EVENT] && !s.q[SYN_EVENT]) ||
                     (s.redirect && trig_ev);
  assign toggle_ev = !s.redirect && trig_ev;
  assign start_ev  = s.s2[SYN_START] && !s.q[SYN_START];
  assign step_ev   = s.s2[SYN_STEP] && !s.q[SYN_STEP];

  // The core reads the current phase, or the scan position while searching.
  assign tbl.idx = (s.state == ST_SEARCH) ? 6'(s.search - PPS_PH_ONE)
                                          : 6'(s.phase - PPS_PH_ONE);
  assign op      = pps_op_type'(tbl.word[PPS_OP_HI:PPS_OP_LO]);
  assign operand = tbl.word[PPS_PH_W-1:0];

  // ----------------------------------------------------------------------
  // Sequencing helpers
  // ----------------------------------------------------------------------
  // Moves on to the next phase; running off the table ends the program.
  function automatic pps_core_type advance(pps_core_type c);
    pps_core_type r;
    r = c;
    r.motor_on = 1'b0;
    if (c.phase == PPS_LAST) begin
      r.state = ST_IDLE;
    end else begin
      r.phase = c.phase + PPS_PH_ONE;
      r.state = ST_FETCH;
    end
    return r;
  endfunction

  // Jumps to a phase; a target outside the table stops with an error.
  function automatic pps_core_type go_to(pps_core_type c, pps_phase_type t);
    pps_core_type r;
    r = c;
    r.motor_on = 1'b0;
    if (t < PPS_FIRST || t > PPS_LAST) begin
      r.state = ST_IDLE;
      r.error = 1'b1;
    end else begin
      r.phase = t;
      r.state = ST_FETCH;
    end
    return r;
  endfunction

  // ----------------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------------
  always_comb begin
    next_s       = s;
    tick_restart = 1'b0;
    next_s.s1    = {step_i, start_i, event_i, trig_i};
    next_s.s2    = s.s1;
    next_s.q     = s.s2;
    next_s.in_s1 = prog_in_i;
    next_s.in_s2 = s.in_s1;
    next_s.ack   = 1'b0;

    // Register access; the answer follows one cycle after the request.
    if (take) begin
      next_s.ack   = 1'b1;
      next_s.rdata = 32'h0;
      if (wb_adr_i == ADR_CTRL) begin
        next_s.rdata[CTRL_PEDAL] = s.pedal;
        if (wb_we_i && wb_sel_i[0]) begin
          next_s.pedal = wb_dat_i[CTRL_PEDAL];
        end
      end else if (wb_adr_i == ADR_STATUS) begin
        next_s.rdata[PPS_PH_W-1:0]                = s.phase;
        next_s.rdata[STAT_RUN]                    = (s.state != ST_IDLE);
        next_s.rdata[STAT_LINE]                   = s.out_line;
        next_s.rdata[STAT_ARMED]                  = s.hook_armed;
        next_s.rdata[STAT_ERROR]                  = s.error;
        next_s.rdata[STAT_REDIR]                  = s.redirect;
        next_s.rdata[STAT_ST_LO +: $bits(s.state)] = s.state;
      end else if (wb_adr_i == ADR_CHOICE) begin
        next_s.rdata[PPS_PH_W-1:0] = s.choice;
        if (wb_we_i && wb_sel_i[0]) begin
          next_s.choice = wb_dat_i[PPS_PH_W-1:0];
        end
      end else if (wb_adr_i == ADR_DISPENSED) begin
        next_s.rdata[PPS_VOL_HI:PPS_VOL_LO] = s.dispensed;
      end else if (tbl_hit) begin
        next_s.rdata = bus_word;
      end
    end

    // Phase execution.
    case (s.state)
      ST_IDLE: begin
        next_s.motor_on = 1'b0;
        if (sw_start) begin
          next_s       = go_to(next_s, PPS_FIRST);
          next_s.error = 1'b0;
        end else if (start_ev || toggle_ev) begin
          next_s.state = ST_FETCH;
        end
      end
      ST_FETCH: begin
        case (op)
          OP_FLOW: begin
            next_s.motor_on  = 1'b1;
            next_s.rate      = tbl.word[PPS_RATE_HI:PPS_RATE_LO];
            next_s.withdraw  = tbl.word[PPS_DIR_BIT];
            next_s.target    = tbl.word[PPS_VOL_HI:PPS_VOL_LO];
            next_s.delivered = 16'h0;
            next_s.is_reload = 1'b0;
            next_s.state     = ST_FLOW;
          end
          OP_RELOAD: begin
            next_s.rate      = tbl.word[PPS_RATE_HI:PPS_RATE_LO];
            next_s.withdraw  = 1'b1;
            next_s.target    = s.dispensed;
            next_s.delivered = 16'h0;
            next_s.is_reload = 1'b1;
            if (s.dispensed == 16'h0) begin
              next_s = advance(next_s);
            end else begin
              next_s.motor_on = 1'b1;
              next_s.state    = ST_FLOW;
            end
          end
          OP_LOOP_BEGIN: begin
            next_s.loop_start = s.phase + PPS_PH_ONE;
            next_s.loop_cnt   = 7'h0;
            next_s            = advance(next_s);
          end
          OP_LOOP_TALLY: begin
            if (s.loop_cnt + 7'h1 >= tbl.word[PPS_CNT_HI:0]) begin
              next_s.loop_cnt = 7'h0;
              next_s          = advance(next_s);
            end else begin
              next_s.loop_cnt = s.loop_cnt + 7'h1;
              next_s          = go_to(next_s, s.loop_start);
            end
          end
          OP_GOTO:         next_s = go_to(next_s, operand);
          OP_CHOICE_HOLD:  next_s.state = ST_CHOICE;
          OP_CHOICE_LABEL: next_s = advance(next_s);
          OP_CLEAR_HOOKS: begin
            next_s.hook_armed = 1'b0;
            next_s            = advance(next_s);
          end
          OP_HOOK_ON: begin
            next_s.hook_armed  = 1'b1;
            next_s.hook_target = operand;
            next_s             = advance(next_s);
          end
          OP_LINE_HIGH: begin
            next_s.out_line = 1'b1;
            next_s          = advance(next_s);
          end
          OP_LINE_LOW: begin
            next_s.out_line = 1'b0;
            next_s          = advance(next_s);
          end
          OP_TIMED_HOLD: begin
            next_s.hold_left = tbl.word[PPS_VOL_HI:PPS_VOL_LO];
            tick_restart     = 1'b1;
            next_s.state     = ST_HOLD;
          end
          OP_BRANCH_LOW: begin
            if (!s.in_s2) begin
              next_s = go_to(next_s, operand);
            end else begin
              next_s = advance(next_s);
            end
          end
          OP_HOOK_REDIR: begin
            next_s.redirect = 1'b1;
            next_s          = advance(next_s);
          end
          default: begin
            next_s.motor_on = 1'b0;
            next_s.state    = ST_IDLE;
          end
        endcase
      end
      ST_FLOW: begin
        if (step_ev) begin
          next_s.delivered = s.delivered + 16'h1;
          if (!s.withdraw) begin
            next_s.dispensed = s.dispensed + 16'h1;
          end else if (s.dispensed != 16'h0) begin
            next_s.dispensed = s.dispensed - 16'h1;
          end
          // A zero target never matches, so the segment runs on.
          if (s.target != 16'h0 && s.delivered + 16'h1 == s.target) begin
            next_s = advance(next_s);
          end
        end
      end
      ST_HOLD: begin
        // A zero-second hold waits for the operator instead.
        if (s.hold_left == 16'h0) begin
          if (start_ev) begin
            next_s = advance(next_s);
          end
        end else if (tick) begin
          if (s.hold_left == 16'h1) begin
            next_s = advance(next_s);
          end else begin
            next_s.hold_left = s.hold_left - 16'h1;
          end
        end
      end
      ST_CHOICE: begin
        if (start_ev) begin
          next_s.search = PPS_FIRST;
          next_s.state  = ST_SEARCH;
        end
      end
      ST_SEARCH: begin
        // Scans one phase per cycle, so selection costs up to 41 cycles.
        if (op == OP_CHOICE_LABEL && operand == s.choice) begin
          next_s = go_to(next_s, s.search);
        end else if (s.search == PPS_LAST) begin
          next_s.error = 1'b1;
          next_s.state = ST_IDLE;
        end else begin
          next_s.search = s.search + PPS_PH_ONE;
        end
      end
      default: next_s.state = ST_IDLE;
    endcase

    // An armed trap aborts any running phase, a hold included.
    if (s.state != ST_IDLE && s.hook_armed && trap_ev) begin
      next_s.hook_armed = 1'b0;
      next_s            = go_to(next_s, s.hook_target);
    end

    // Stop requests win over everything else.
    if (sw_stop || (s.state != ST_IDLE && toggle_ev)) begin
      next_s.motor_on = 1'b0;
      next_s.state    = ST_IDLE;
    end
  end

  // ----------------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s       <= '0;
      s.state <= ST_IDLE;
      s.phase <= PPS_FIRST;
    end else begin
      s <= next_s;
    end
  end

  // ----------------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------------
  assign wb_dat_o         = s.rdata;
  assign wb_ack_o         = s.ack;
  assign prog_out_o       = s.out_line;
  assign motor_on_o       = s.motor_on;
  assign motor_withdraw_o = s.withdraw;
  assign motor_rate_o     = s.rate;
  assign running_o        = (s.state != ST_IDLE);
  assign phase_o          = s.phase;

endmodule

// *** src/pps_tbl_if.sv ***
// Purpose: Carries the sequencer's phase table read between core and table.
// Assumes: Index is zero based, phase number minus one.
// Notes:   Read is combinational inside the table.

`timescale 1ns/10ps

interface pps_tbl_if;
  logic [5:0]  idx;
  logic [31:0] word;
  modport seq (output idx, input word);
  modport mem (input idx, output word);
endinterface
